// ==== pkg/gcp_consts.vh ====
// register offsets, reset values and widths for the change-irq / drive / pull-up block
// assumes a 32-bit word-addressed plain register port with byte offsets
`ifndef GCP_CONSTS_VH
`define GCP_CONSTS_VH
`define GCP_AW              8
`define GCP_DW              32
`define GCP_OFF_PIN_LEVEL   8'h00
`define GCP_OFF_IRQ_EN      8'h04
`define GCP_OFF_IRQ_DIS     8'h08
`define GCP_OFF_IRQ_MASK    8'h0c
`define GCP_OFF_IRQ_STAT    8'h10
`define GCP_OFF_OD_EN       8'h14
`define GCP_OFF_OD_DIS      8'h18
`define GCP_OFF_OD_STAT     8'h1c
`define GCP_OFF_PU_DIS      8'h20
`define GCP_OFF_PU_EN       8'h24
`define GCP_OFF_PU_STAT     8'h28
`define GCP_RST_MASK        32'h00000000
`define GCP_RST_OD          32'h00000000
`define GCP_RST_PU_ON       32'hffffffff
`define GCP_RST_ZERO        32'h00000000
`endif

// ==== rtl/gcp_gpio.v ====
// 32-line parallel io slice: pin level readout, change interrupts, open-drain and pull-up control
// assumes pad inputs synchronous to clk_sys and output data/enable supplied from elsewhere
// Contract
// - pin level register reads the sampled level of each line
// - writing ones to irq enable sets mask bits, zeros ignored
// - writing ones to irq disable clears mask bits, zeros ignored
// - mask register is read only, one means change interrupt enabled
// - status bit sets on any level change since last read or reset
// - reading status clears all bits except those with a change in the reading cycle; reset clears too
// - writing ones to open-drain enable turns open-drain on, zeros ignored
// - writing ones to open-drain disable turns open-drain off, zeros ignored
// - open-drain line drives low only; status reads one
// - push-pull line drives both levels; status reads zero
// - writing ones to pull-up disable switches pull-up off, zeros ignored
// - writing ones to pull-up enable switches pull-up on, zeros ignored
// - pull-up status reads zero when enabled, one when disabled
`timescale 1ns/1ns
`include "gcp_consts.vh"
module gcp_gpio
(
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire [31:0] line_out_data,
  input  wire [31:0] line_out_en,
  input  wire [31:0] pad_in,
  output wire [31:0] pad_out,
  output wire [31:0] pad_oe,
  output wire [31:0] pad_pullup_en,
  output wire        irq
);

  reg  [31:0] pin_sync;
  reg  [31:0] pin_level;
  reg  [31:0] irq_mask;
  reg  [31:0] irq_stat;
  reg  [31:0] od_en;
  reg  [31:0] pu_on;
  reg  [31:0] next_rdata;
  wire [31:0] change;
  wire        wr_irq_en;
  wire        wr_irq_dis;
  wire        wr_od_en;
  wire        wr_od_dis;
  wire        wr_pu_en;
  wire        wr_pu_dis;
  wire        rd_stat;

  assign wr_irq_en  = reg_wr && (reg_addr == `GCP_OFF_IRQ_EN);
  assign wr_irq_dis = reg_wr && (reg_addr == `GCP_OFF_IRQ_DIS);
  assign wr_od_en   = reg_wr && (reg_addr == `GCP_OFF_OD_EN);
  assign wr_od_dis  = reg_wr && (reg_addr == `GCP_OFF_OD_DIS);
  assign wr_pu_en   = reg_wr && (reg_addr == `GCP_OFF_PU_EN);
  assign wr_pu_dis  = reg_wr && (reg_addr == `GCP_OFF_PU_DIS);
  assign rd_stat    = reg_rd && (reg_addr == `GCP_OFF_IRQ_STAT);

  // pad sampling: first stage feeds only the second
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_sync  <= `GCP_RST_ZERO;
      pin_level <= `GCP_RST_ZERO;
    end
    else
    begin
      pin_sync  <= pad_in;
      pin_level <= pin_sync;
    end
  end

  reg [31:0] pin_prev;
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pin_prev <= `GCP_RST_ZERO;
    else
      pin_prev <= pin_level;
  end

  // compare held off until pin_prev holds a real sample, so a high pad at reset is no change
  reg [2:0] prev_valid;
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      prev_valid <= 3'h0;
    else
      prev_valid <= {prev_valid[1:0], 1'b1};
  end

  assign change = prev_valid[2] ? (pin_level ^ pin_prev) : `GCP_RST_ZERO;

  // per-line control and status state
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1)
    begin : g_line
      always @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
        begin
          irq_mask[i] <= 1'b0;
          od_en[i]    <= 1'b0;
          pu_on[i]    <= 1'b1;
          irq_stat[i] <= 1'b0;
        end
        else
        begin
          if (wr_irq_en && reg_wdata[i])
            irq_mask[i] <= 1'b1;
          else if (wr_irq_dis && reg_wdata[i])
            irq_mask[i] <= 1'b0;
          if (wr_od_en && reg_wdata[i])
            od_en[i] <= 1'b1;
          else if (wr_od_dis && reg_wdata[i])
            od_en[i] <= 1'b0;
          if (wr_pu_en && reg_wdata[i])
            pu_on[i] <= 1'b1;
          else if (wr_pu_dis && reg_wdata[i])
            pu_on[i] <= 1'b0;
          // a change in the reading cycle survives the clear
          if (change[i])
            irq_stat[i] <= 1'b1;
          else if (rd_stat)
            irq_stat[i] <= 1'b0;
        end
      end
      // open-drain: drive only when output data is low
      assign pad_oe[i]  = line_out_en[i] && (!od_en[i] || !line_out_data[i]);
      assign pad_out[i] = od_en[i] ? 1'b0 : line_out_data[i];
    end
  endgenerate

  assign pad_pullup_en = pu_on;
  assign irq = |(irq_stat & irq_mask);

  // read mux; unmapped and write-only offsets read zero
  always @*
  begin
    next_rdata = `GCP_RST_ZERO;
    case (reg_addr)
      `GCP_OFF_PIN_LEVEL: next_rdata = pin_level;
      `GCP_OFF_IRQ_MASK:  next_rdata = irq_mask;
      `GCP_OFF_IRQ_STAT:  next_rdata = irq_stat;
      `GCP_OFF_OD_STAT:   next_rdata = od_en;
      `GCP_OFF_PU_STAT:   next_rdata = ~pu_on;
      default:            next_rdata = `GCP_RST_ZERO;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= `GCP_RST_ZERO;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= `GCP_RST_ZERO;
  end

endmodule // gcp_gpio

// ==== tb/gcp_pads.sv ====
// outside pads: a driven line follows the device, a released one the outside level
// assumes ext_drv comes from the bench
`timescale 1ns/1ns
module gcp_pads
(
  input  [31:0] pad_out,
  input  [31:0] pad_oe,
  input  [31:0] ext_drv,
  output [31:0] pad_in
);
  assign pad_in = pad_oe & pad_out | ~pad_oe & ext_drv;
endmodule // gcp_pads

// ==== tb/gcp_gpio_assertions.sv ====
// port checks for gcp_gpio
// assumes the offsets of gcp_consts.vh
`timescale 1ns/1ns
module gcp_chk
(
  input        clk_sys, arst_n, reg_wr, reg_rd, irq,
  input [7:0]  reg_addr,
  input [31:0] reg_wdata, reg_rdata, line_out_data, line_out_en, pad_in, pad_oe, pad_pullup_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence quiet_rd; $stable(pad_in)[*4] ##0 reg_rd && reg_addr == 8'h10; endsequence
  sequence change_rd; $changed(pad_in) ##3 reg_rd && reg_addr == 8'h10; endsequence
  a_pin_read: assert property (reg_rd && reg_addr == 8'h00 && $past(arst_n, 3) |=> reg_rdata == $past(pad_in, 3))
    else $error("pin");
  a_read_clear: assert property (quiet_rd |=> !irq)
    else $error("clear");
  a_change_seen: assert property (change_rd |=> (reg_rdata & ($past(pad_in, 4) ^ $past(pad_in, 5))) != 0)
    else $error("change");
  a_irq_cause: assert property ($rose(irq) |-> $past(reg_wr) || $past(pad_in, 3) != $past(pad_in, 4))
    else $error("irq");
  a_od_on: assert property (reg_wr && reg_addr == 8'h14 |=> !(pad_oe & line_out_data & $past(reg_wdata)))
    else $error("od on");
  a_od_off: assert property (reg_wr && reg_addr == 8'h18 |=> !((pad_oe ^ line_out_en) & $past(reg_wdata)))
    else $error("od off");
  a_pu_off: assert property (reg_wr && reg_addr == 8'h20 |=> !(pad_pullup_en & $past(reg_wdata)))
    else $error("pu off");
  a_pu_on: assert property (reg_wr && reg_addr == 8'h24 |=> !(~pad_pullup_en & $past(reg_wdata)))
    else $error("pu on");
endmodule // gcp_chk
bind gcp_gpio gcp_chk i_chk (.*);

// ==== tb/testbench.sv ====
// bench for gcp_gpio with the pad model
// assumes the offsets of gcp_consts.vh
`timescale 1ns/1ns
module testbench;
  reg clk_sys = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
  reg [7:0] reg_addr = 0, so [3] = '{8'h04, 8'h14, 8'h20};
  reg [31:0] reg_wdata = 0, line_out_data = 0, line_out_en = 0, ext = 0, seed = 32'h5a, r, e, sh [3] = '{0, 0, 0};
  wire [31:0] reg_rdata, pad_in, pad_out, pad_oe, pad_pullup_en;
  wire irq;
  integer mismatches = 0, checks_done = 0, i, k;
  gcp_gpio i_dut (.*);
  gcp_pads i_pads (.pad_out, .pad_oe, .ext_drv(ext), .pad_in);
  initial forever #4 clk_sys = ~clk_sys;
  function [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input [31:0] s, input [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      mismatches++;
      $display("unexpected at %0t: %h vs %h", $time, s, x);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys) reg_wr <= 0;
  endtask
  task rd(input [7:0] a, input [31:0] x, input [31:0] m);
    @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys) reg_rd <= 0;
    #1 chk(reg_rdata & m, x & m);
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1;
    wr(8'h0c, ~32'h0);
    rd(8'h2c, 32'h0, ~32'h0);
    for (k = 0; k < 3; k++) rd(so[k] + 8'h08, 32'h0, ~32'h0);
    for (i = 0; i < 30; i++)
    begin
      k = i % 3;
      r = xs();
      wr(so[k], r);
      sh[k] |= r;
      r = xs();
      wr(so[k] + 8'h04, r);
      sh[k] &= ~r;
      rd(so[k] + 8'h08, sh[k], ~32'h0);
      @(posedge clk_sys) {line_out_en, line_out_data, ext} <= {xs(), xs(), xs()};
      repeat (3) @(posedge clk_sys);
      r = line_out_en & ~(sh[1] & line_out_data);
      #1 chk(pad_oe, r);
      chk(pad_out & r, line_out_data & r);
      chk(pad_pullup_en, ~sh[2]);
      rd(8'h00, r & line_out_data | ~r & ext, ~32'h0);
    end
    @(posedge clk_sys) line_out_en <= 32'h0;
    wr(8'h04, ~32'h0);
    repeat (4) @(posedge clk_sys);
    rd(8'h10, 32'h0, 32'h0);
    rd(8'h10, 32'h0, ~32'h0);
    e = xs();
    @(posedge clk_sys) ext <= ext ^ e;
    repeat (3) @(posedge clk_sys);
    #1 chk(irq, 1);
    rd(8'h10, e, ~32'h0);
    chk(irq, 0);
    wr(8'h08, ~32'h0);
    @(posedge clk_sys) ext <= ext ^ e;
    repeat (2) @(posedge clk_sys);
    rd(8'h10, e, ~32'h0);
    chk(irq, 0);
    results;
  end
  initial
  begin
    #20000;
    mismatches++;
    results;
  end
endmodule // testbench
